/* File: design/pwm_timebase_cfg.svh */
`ifndef PWM_TIMEBASE_CFG_SVH
`define PWM_TIMEBASE_CFG_SVH

// Register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_COUNTER 12'h004
`define OFS_PERIOD 12'h008
`define OFS_DUTY0 12'h00c
`define OFS_DUTY1 12'h010
`define OFS_DUTY2 12'h014

// Control register field positions
`define CTL_ENABLE_BIT 15
`define CTL_POST_HI 7
`define CTL_POST_LO 4
`define CTL_PRE_HI 3
`define CTL_PRE_LO 2
`define CTL_MODE_HI 1
`define CTL_MODE_LO 0

// Counter register direction bit
`define CNT_DIR_BIT 15

// Prescale divide terminal counts (divide minus one)
`define PRE_DIV1_LAST 6'h00
`define PRE_DIV4_LAST 6'h03
`define PRE_DIV16_LAST 6'h0f
`define PRE_DIV64_LAST 6'h3f

// Reset values
`define RST_COUNT 15'h0000
`define RST_PERIOD 15'h0000
`define RST_DUTY 15'h0000
`define RST_POST 4'h0
`define RST_PRE 6'h00

`endif

/* File: design/pwm_timebase_pkg.sv */
package pwm_timebase_pkg;

	// Time base operating modes
	typedef enum logic [1:0] {
		MODE_FREE_RUN = 2'b00,
		MODE_SINGLE_SHOT = 2'b01,
		MODE_UP_DOWN = 2'b10,
		MODE_UP_DOWN_DOUBLE = 2'b11
	} timebase_mode_t;

	// Prescale selections
	typedef enum logic [1:0] {
		PRE_DIV1 = 2'b00,
		PRE_DIV4 = 2'b01,
		PRE_DIV16 = 2'b10,
		PRE_DIV64 = 2'b11
	} prescale_t;

	// Software-visible control fields
	typedef struct packed {
		logic timebase_enable;
		logic [3:0] postscale_select;
		prescale_t prescale_select;
		timebase_mode_t timebase_mode_select;
	} timebase_control_t;

	// Compare outputs, one high/low pair per channel
	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} pwm_pair_t;

endpackage

/* File: design/pwm_timebase_and_compare.sv */
// What this block does
// - 15-bit count, bit 15 reads direction
// - Direction reads 0 up, 1 down
// - Enable runs counter; clearing keeps count
// - Period match resets or reverses next tick
// - Zero period stops; no zero update enabled
// - Mode field selects four time base modes
// - Free-run: wrap at match, postscaled event
// - Single-shot: wrap, clear enable, raw event
// - Up/down: event at zero, postscaled
// - Double update: events at zero and match
// - Prescale divides by 1, 4, 16, 64
// - Counter or control write clears prescaler
// - Four-bit postscaler divides 1 to 16
// - Counter or control write clears postscaler
// - Period buffer loads at wrap, zero, disable
// - Edge modes edge-aligned, up/down center-aligned
// - Edge: active at zero, off at duty
// - Edge: duty zero off, above period on
// - Center: on at match down, off up
// - Center: duty zero off, equal period on
// - Three comparators drive high/low pairs
//
// Added by the designer: the register offsets and the APB register port.
`include "pwm_timebase_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pwm_timebase_and_compare
	import pwm_timebase_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output pwm_pair_t pwm_out,
	output logic timer_event
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	timebase_control_t ctl_q;
	logic [14:0] count_q;
	logic count_direction_q;
	logic [14:0] period_buf_q;
	logic [14:0] period_q;
	logic [14:0] duty_q [0:2];
	logic [5:0] pre_cnt_q;
	logic [3:0] post_cnt_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [2:0] cmp_q;
	logic timer_event_q;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic wr_en;
	logic rd_setup;
	logic wr_ctl;
	logic wr_cnt;
	logic wr_per;
	logic mapped;

	// Tests whether an address selects a given register
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign wr_ctl = wr_en && hit(paddr, `OFS_CONTROL);
	assign wr_cnt = wr_en && hit(paddr, `OFS_COUNTER);
	assign wr_per = wr_en && hit(paddr, `OFS_PERIOD);
	assign mapped = hit(paddr, `OFS_CONTROL) || hit(paddr, `OFS_COUNTER)
		|| hit(paddr, `OFS_PERIOD) || hit(paddr, `OFS_DUTY0)
		|| hit(paddr, `OFS_DUTY1) || hit(paddr, `OFS_DUTY2);

	// Zero-wait access phase; read data prepared in setup
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	// ----------------------------------------
	// Prescaler tick
	// ----------------------------------------
	logic [5:0] pre_last;
	logic tick;
	logic running;
	logic per_zero;

	// Terminal count for selected division
	always_comb
	begin
		case (ctl_q.prescale_select)
			PRE_DIV1: pre_last = `PRE_DIV1_LAST;
			PRE_DIV4: pre_last = `PRE_DIV4_LAST;
			PRE_DIV16: pre_last = `PRE_DIV16_LAST;
			PRE_DIV64: pre_last = `PRE_DIV64_LAST;
			default: pre_last = `PRE_DIV1_LAST;
		endcase
	end

	assign per_zero = (period_q == `RST_PERIOD);
	assign running = ctl_q.timebase_enable && !per_zero;
	assign tick = running && (pre_cnt_q == pre_last);

	// Prescale counter, cleared by control and counter writes
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			pre_cnt_q <= `RST_PRE;
		else if (wr_ctl || wr_cnt)
			pre_cnt_q <= `RST_PRE;
		else if (!running || tick)
			pre_cnt_q <= `RST_PRE;
		else
			pre_cnt_q <= pre_cnt_q + 6'h01;
	end

	// ----------------------------------------
	// Time base counter
	// ----------------------------------------
	logic is_center;
	logic at_match;
	logic wrap;
	logic turn_down;
	logic turn_up;
	logic raw_event;
	logic post_mode;

	assign is_center = ctl_q.timebase_mode_select[1];
	assign at_match = !count_direction_q && (count_q == period_q);
	assign wrap = tick && at_match && !is_center;
	assign turn_down = tick && at_match && is_center;
	assign turn_up = tick && count_direction_q && (count_q == 15'h0001);
	// Raw events per mode
	assign raw_event = wrap
		|| (turn_up && is_center)
		|| (turn_down && ctl_q.timebase_mode_select == MODE_UP_DOWN_DOUBLE);
	assign post_mode = (ctl_q.timebase_mode_select == MODE_FREE_RUN)
		|| (ctl_q.timebase_mode_select == MODE_UP_DOWN);

	// Count value; write of bits 14:0 loads it, bit 15 is read-only
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			count_q <= `RST_COUNT;
		else if (wr_cnt)
			count_q <= pwdata[14:0];
		else if (wrap)
			count_q <= `RST_COUNT;
		else if (turn_down)
			count_q <= count_q - 15'h0001;
		else if (tick && count_direction_q)
			count_q <= count_q - 15'h0001;
		else if (tick)
			count_q <= count_q + 15'h0001;
	end

	// Count direction: 0 up, 1 down
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			count_direction_q <= 1'b0;
		else if (!is_center)
			count_direction_q <= 1'b0;
		else if (turn_down)
			count_direction_q <= 1'b1;
		else if (turn_up)
			count_direction_q <= 1'b0;
	end

	// Control register; single-shot wrap clears enable
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctl_q <= '0;
		else if (wr_ctl)
		begin
			ctl_q.timebase_enable <= pwdata[`CTL_ENABLE_BIT];
			ctl_q.postscale_select <= pwdata[`CTL_POST_HI:`CTL_POST_LO];
			ctl_q.prescale_select <= prescale_t'(pwdata[`CTL_PRE_HI:`CTL_PRE_LO]);
			ctl_q.timebase_mode_select <=
				timebase_mode_t'(pwdata[`CTL_MODE_HI:`CTL_MODE_LO]);
		end
		else if (wrap && ctl_q.timebase_mode_select == MODE_SINGLE_SHOT)
			ctl_q.timebase_enable <= 1'b0;
	end

	// ----------------------------------------
	// Period double buffer
	// ----------------------------------------
	logic per_load;

	// Load at wrap, at the turn to zero, or whenever disabled
	assign per_load = !ctl_q.timebase_enable
		|| (!per_zero && (wrap || turn_up));

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			period_buf_q <= `RST_PERIOD;
		else if (wr_per)
			period_buf_q <= pwdata[14:0];
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			period_q <= `RST_PERIOD;
		else if (per_load)
			period_q <= period_buf_q;
	end

	// ----------------------------------------
	// Postscaler and event output
	// ----------------------------------------
	logic post_fire;

	assign post_fire = raw_event && post_cnt_q == ctl_q.postscale_select;

	// Postscale counter, cleared by control and counter writes
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			post_cnt_q <= `RST_POST;
		else if (wr_ctl || wr_cnt)
			post_cnt_q <= `RST_POST;
		else if (raw_event && post_mode)
			post_cnt_q <= post_fire ? `RST_POST : post_cnt_q + 4'h1;
	end

	// One-cycle event pulse
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			timer_event_q <= 1'b0;
		else
			timer_event_q <= post_mode ? post_fire : raw_event;
	end

	assign timer_event = timer_event_q;

	// ----------------------------------------
	// Duty registers and comparators
	// ----------------------------------------
	// Duty register writes
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			duty_q[0] <= `RST_DUTY;
			duty_q[1] <= `RST_DUTY;
			duty_q[2] <= `RST_DUTY;
		end
		else if (wr_en)
		begin
			if (hit(paddr, `OFS_DUTY0))
				duty_q[0] <= pwdata[14:0];
			if (hit(paddr, `OFS_DUTY1))
				duty_q[1] <= pwdata[14:0];
			if (hit(paddr, `OFS_DUTY2))
				duty_q[2] <= pwdata[14:0];
		end
	end

	// Three independent compare outputs
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cmp_q <= 3'h0;
		else
			for (int ch = 0; ch < 3; ch++)
			begin
				if (duty_q[ch] == `RST_DUTY)
					cmp_q[ch] <= 1'b0;
				else if (!is_center)
				begin
					if (duty_q[ch] > period_q)
						cmp_q[ch] <= 1'b1;
					else if (count_q == duty_q[ch])
						cmp_q[ch] <= 1'b0;
					else if (count_q == `RST_COUNT)
						cmp_q[ch] <= 1'b1;
				end
				else if (duty_q[ch] >= period_q)
					cmp_q[ch] <= 1'b1;
				else if (count_q == duty_q[ch])
					cmp_q[ch] <= count_direction_q;
			end
	end

	// One driver for the whole pair; low is the complement of high
	assign pwm_out = '{high: cmp_q, low: ~cmp_q};

	// ----------------------------------------
	// Read data, captured in the setup cycle
	// ----------------------------------------
	logic [31:0] rd_word;

	// Read multiplexer
	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (hit(paddr, `OFS_CONTROL))
		begin
			rd_word[`CTL_ENABLE_BIT] = ctl_q.timebase_enable;
			rd_word[`CTL_POST_HI:`CTL_POST_LO] = ctl_q.postscale_select;
			rd_word[`CTL_PRE_HI:`CTL_PRE_LO] = ctl_q.prescale_select;
			rd_word[`CTL_MODE_HI:`CTL_MODE_LO] = ctl_q.timebase_mode_select;
		end
		else if (hit(paddr, `OFS_COUNTER))
		begin
			rd_word[14:0] = count_q;
			rd_word[`CNT_DIR_BIT] = count_direction_q;
		end
		else if (hit(paddr, `OFS_PERIOD))
			rd_word[14:0] = period_buf_q;
		else if (hit(paddr, `OFS_DUTY0))
			rd_word[14:0] = duty_q[0];
		else if (hit(paddr, `OFS_DUTY1))
			rd_word[14:0] = duty_q[1];
		else if (hit(paddr, `OFS_DUTY2))
			rd_word[14:0] = duty_q[2];
	end

	// Registered read data and error answer
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else if (rd_setup)
		begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
			pslverr_q <= !mapped;
		end
	end

endmodule

`default_nettype wire

/* File: bench/pwm_tb_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_tb_checker
	import pwm_timebase_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire pwm_pair_t pwm_out,
	input wire logic timer_event
);
	// ----------------------------
	// Bus and event properties
	// ----------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic mapped;
	// Decode of the six register words
	assign mapped = paddr <= 12'h014 && paddr[1:0] == 2'h0;
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_stop;
		psel && penable && pwrite && paddr == 12'h000 && !pwdata[15];
	endsequence
	chk_ready_high: assert property (pready) else $error("pready low");
	chk_pair_inverse: assert property (pwm_out.low == ~pwm_out.high)
		else $error("low not complement of high");
	chk_event_single: assert property (timer_event |=> !timer_event)
		else $error("event longer than one cycle");
	chk_unmapped_err: assert property (s_setup ##0 !mapped |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_mapped_ok: assert property (s_setup ##0 mapped |=> !pslverr)
		else $error("mapped access refused");
	chk_upper_zero: assert property (s_setup |=> prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	chk_read_holds: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
		else $error("read answer changed");
	chk_stop_quiet: assert property (s_stop |=> ##3 !timer_event [*4])
		else $error("event after disable");
endmodule
bind pwm_timebase_and_compare pwm_tb_checker pwm_tb_checker_i (.sys_clk(sys_clk),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pwm_out(pwm_out), .timer_event(timer_event));
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pwm_timebase_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, v;
	logic pready, pslverr, timer_event;
	pwm_pair_t pwm_out;
	int bad_count = 0, n_compared = 0, ne, a, b, p, post, hi[3];
	int modes[4] = '{0, 2, 3, 0};
	pwm_timebase_and_compare pwm_timebase_and_compare_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out),
		.timer_event(timer_event));
	// ----------------------------
	// Clock, helpers
	// ----------------------------
	always #12.5 sys_clk = ~sys_clk;
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	// One APB transfer, held until pready is seen
	task apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= ad;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task cfg(input int m, pp, pre, ps, d1, d2);
		apb(12'h000, 1'b1, 32'h0);
		apb(12'h004, 1'b1, 32'h0);
		apb(12'h008, 1'b1, pp);
		apb(12'h00c, 1'b1, 32'h0);
		apb(12'h010, 1'b1, d1);
		apb(12'h014, 1'b1, d2);
		apb(12'h000, 1'b1, 32'h8000 | ps << 4 | pre << 2 | m);
	endtask
	task wait_ev(output int n);
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (timer_event !== 1'b1 && n < 20000);
	endtask
	task watch(input int c);
		ne = 0;
		hi = '{0, 0, 0};
		repeat (c)
		begin
			@(posedge sys_clk);
			ne += (timer_event === 1'b1);
			for (int i = 0; i < 3; i++)
				hi[i] += (pwm_out.high[i] === 1'b1);
		end
	endtask
	// Cycles spanned by three consecutive events (two event gaps)
	function int ev_gap(int m, pp, pre, ps);
		int d;
		d = (1 << 2 * pre) * (m == 3 ? 1 : 2 * (ps + 1));
		return d * (m == 0 ? pp + 1 : 2 * pp);
	endfunction
	// ----------------------------
	// Tests
	// ----------------------------
	initial
	begin
		#(25 * 90000);
		bad_count++;
		report_and_stop;
	end
	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		void'($urandom(84152));
		for (int i = 0; i < 6; i++)
		begin
			apb(12'(i * 4), 1'b0, 32'h0);
			chk("reset value", 32'h0, rd);
		end
		apb(12'h018, 1'b0, 32'h0);
		v = $urandom & 32'h00ff;
		apb(12'h000, 1'b1, v);
		apb(12'h000, 1'b0, 32'h0);
		chk("control", v, rd);
		v = $urandom | 32'h8000;
		apb(12'h004, 1'b1, v);
		apb(12'h004, 1'b0, 32'h0);
		chk("counter", v & 32'h7fff, rd);
		$display("test registers done");
		for (int k = 0; k < 4; k++)
		begin
			// Period of one is never programmed
			p = 2 + $urandom % 4;
			post = $urandom % 4;
			cfg(modes[k], p, k, post, 0, 0);
			wait_ev(a);
			wait_ev(a);
			wait_ev(b);
			chk("event gap", ev_gap(modes[k], p, k, post), a + b);
		end
		$display("test event rate done");
		cfg(1, 4, 0, 3, 0, 0);
		watch(40);
		chk("single events", 1, ne);
		apb(12'h000, 1'b0, 32'h0);
		chk("enable cleared", 32'h0, rd & 32'h8000);
		apb(12'h004, 1'b0, 32'h0);
		chk("count cleared", 32'h0, rd);
		$display("test single shot done");
		cfg(0, 0, 0, 0, 0, 0);
		apb(12'h008, 1'b1, 32'h5);
		watch(100);
		chk("zero period", 0, ne);
		$display("test zero period done");
		cfg(0, 20000, 3, 0, 0, 0);
		repeat (300) @(posedge sys_clk);
		// Counter write restarts the 1:64 prescaler: first tick 64 cycles on
		apb(12'h004, 1'b1, 32'h64);
		repeat (60) @(posedge sys_clk);
		apb(12'h004, 1'b0, 32'h0);
		chk("prescale cleared", 32'h64, rd);
		apb(12'h004, 1'b0, 32'h0);
		chk("first tick", 32'h65, rd);
		apb(12'h000, 1'b1, 32'h0);
		apb(12'h004, 1'b0, 32'h0);
		v = rd;
		chk("count kept", 1, v > 100);
		watch(300);
		apb(12'h004, 1'b0, 32'h0);
		chk("held count", v, rd);
		$display("test disable done");
		// Up/down, period 3 at 1:64; new period 6 buffered mid-count
		cfg(2, 3, 3, 0, 0, 0);
		apb(12'h008, 1'b1, 32'h6);
		repeat (297) @(posedge sys_clk);
		apb(12'h004, 1'b0, 32'h0);
		chk("old period down", 32'h8002, rd);
		repeat (495) @(posedge sys_clk);
		apb(12'h004, 1'b0, 32'h0);
		chk("new period up", 32'h0006, rd);
		$display("test period buffer done");
		for (int m = 0; m < 3; m += 2)
		begin
			cfg(m, 7, 0, 0, 3, m == 0 ? 9 : 7);
			watch(40);
			watch(56);
			chk("duty zero", 0, hi[0]);
			chk("duty mid", m == 0 ? 21 : 24, hi[1]);
			chk("duty full", 56, hi[2]);
		end
		$display("test compare done");
		report_and_stop;
	end
endmodule
`default_nettype wire
